// [core/pif_consts.svh]
`ifndef PIF_CONSTS_SVH
`define PIF_CONSTS_SVH

// ----------------------------------------
// Register byte offsets (low address bits)
// ----------------------------------------
`define PIF_ADDR_BITS 8
`define PIF_OFF_FLAGS_1 8'h00
`define PIF_OFF_FLAGS_2 8'h04
`define PIF_OFF_ENABLE_1 8'h08
`define PIF_OFF_ENABLE_2 8'h0c
`define PIF_OFF_CONTROL 8'h10
`define PIF_OFF_PENDING 8'h14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PIF_RST_FLAGS 8'h00
`define PIF_RST_ENABLE 8'h00
`define PIF_RST_CONTROL 2'h0

// ----------------------------------------
// Field positions, first request register
// ----------------------------------------
`define PIF_F1_TIMER1_GATE 7
`define PIF_F1_ADC_DONE 6
`define PIF_F1_SERIAL_RX 5
`define PIF_F1_SERIAL_TX 4
`define PIF_F1_SYNC_SERIAL 3
`define PIF_F1_CAPCOMP1 2
`define PIF_F1_TIMER2_MATCH 1
`define PIF_F1_TIMER1_OVF 0

// ----------------------------------------
// Field positions, second request register
// ----------------------------------------
`define PIF_F2_OSC_FAIL 7
`define PIF_F2_COMPARATOR2 6
`define PIF_F2_COMPARATOR1 5
`define PIF_F2_EEPROM_DONE 4
`define PIF_F2_BUS_COLLISION 3
`define PIF_F2_LCD_EVENT 2
`define PIF_F2_UNUSED 1
`define PIF_F2_CAPCOMP2 0

// ----------------------------------------
// Access masks
// ----------------------------------------
`define PIF_F1_RO_MASK 8'h30
`define PIF_F1_IMPL_MASK 8'hff
`define PIF_F2_IMPL_MASK 8'hfd

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PIF_CTL_PERIPH_EN 0
`define PIF_CTL_GLOBAL_EN 1

`endif

// [core/pif_pkg.sv]
package pif_pkg;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [7:0] pif_flags_t;

	typedef enum logic {
		BUS_IDLE,
		BUS_ACCESS
	} pif_bus_e;

endpackage : pif_pkg

// [core/pif_top.sv]
`timescale 1ns/100ps
`default_nettype none

`include "pif_consts.svh"

// Overview of operation
// R1: A flag sets on its event regardless of enable bits or global enable.
// R2: Software should clear a flag before enabling its interrupt.
// R3: Each implemented flag reads 1 while pending, 0 when not pending.
// R4: All flags in both request registers reset to zero on every reset.
// R5: Register one: bit 7 timer-1 gate, bit 1 timer-2 match, bit 0 overflow.
// R6: Register one bit 6 reports ADC completion; software reads and writes it.
// R7: Register one bit 5 reports serial receive; writes never change it.
// R8: Register one bit 4 reports serial transmit; writes never change it.
// R9: Register one bit 3 sync serial, bit 2 capture unit one; both writable.
// R10: Register two: bit 7 oscillator fail, bit 6 comparator 2, bit 5 comparator 1.
// R11: Register two: bit 4 EEPROM write done, bit 3 bus collision.
// R12: Register two: bit 2 LCD event, bit 0 capture unit two; both writable.
// R13: Register two bit 1 always reads zero and ignores writes.
// R14: Interrupt reaches processor only with peripheral enable set plus its own enable; the code also requires the global enable bit.
// R15: Writing 0 clears, 1 sets a writable flag; hardware set beats clear.
module pif_top import pif_pkg::*; #(
	parameter int FLAG_WIDTH = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic timer1_gate_event,
	input wire logic adc_done_event,
	input wire logic serial_rx_pending,
	input wire logic serial_tx_pending,
	input wire logic sync_serial_event,
	input wire logic capcomp_unit1_event,
	input wire logic timer2_match_event,
	input wire logic timer1_overflow_event,
	input wire logic osc_fail_event,
	input wire logic comparator_two_event,
	input wire logic comparator_one_event,
	input wire logic eeprom_write_done_event,
	input wire logic bus_collision_event,
	input wire logic lcd_event,
	input wire logic capcomp_unit2_event,
	output logic [7:0] peripheral_request_flags_1,
	output logic [7:0] peripheral_request_flags_2,
	output logic peripheral_irq_request
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	localparam pif_flags_t F1_RO = `PIF_F1_RO_MASK;
	localparam pif_flags_t F2_IMPL = `PIF_F2_IMPL_MASK;
	localparam pif_flags_t SERIAL_BITS = (8'h01 << `PIF_F1_SERIAL_RX) | (8'h01 << `PIF_F1_SERIAL_TX);

	if (FLAG_WIDTH != 8) begin : g_width_check
		$error("pif_top: FLAG_WIDTH must be 8");
	end

	// Read-only mask must shield exactly the serial level bits
	if (F1_RO != SERIAL_BITS) begin : g_ro_check
		$error("pif_top: read-only mask must cover the serial bits");
	end

	// Unused bit of register two must never be stored
	if (F2_IMPL[`PIF_F2_UNUSED] != 1'b0) begin : g_unused_check
		$error("pif_top: unused bit must lie outside the implemented mask");
	end

	// Decoder needs enough address bits to reach the highest offset
	if (`PIF_ADDR_BITS < 5) begin : g_addr_check
		$error("pif_top: address decode too narrow");
	end

	// Control register is only two bits wide
	if (`PIF_CTL_PERIPH_EN > 1 || `PIF_CTL_GLOBAL_EN > 1) begin : g_ctl_check
		$error("pif_top: control field outside the control register");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	pif_bus_e bus_state_reg;
	pif_bus_e bus_state_next;
	logic [`PIF_ADDR_BITS-1:0] addr_reg;
	logic write_reg;
	logic [31:0] hrdata_reg;
	logic hreadyout_reg;
	logic hresp_reg;

	pif_flags_t flags_1_reg;
	pif_flags_t flags_1_next;
	pif_flags_t flags_2_reg;
	pif_flags_t flags_2_next;
	pif_flags_t enable_1_reg;
	pif_flags_t enable_2_reg;
	logic [1:0] control_reg;
	logic irq_reg;
	logic irq_next;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic take_req;
	logic do_access;
	logic do_write;
	logic wr_flags_1;
	logic wr_flags_2;
	logic wr_enable_1;
	logic wr_enable_2;
	logic wr_control;
	logic [31:0] read_mux;

	// Address phase is accepted only while the bus is ready.
	assign take_req = hsel & hready & htrans[1];
	assign do_access = (bus_state_reg == BUS_ACCESS);
	assign do_write = do_access & write_reg;
	assign wr_flags_1 = do_write & (addr_reg == `PIF_OFF_FLAGS_1);
	assign wr_flags_2 = do_write & (addr_reg == `PIF_OFF_FLAGS_2);
	assign wr_enable_1 = do_write & (addr_reg == `PIF_OFF_ENABLE_1);
	assign wr_enable_2 = do_write & (addr_reg == `PIF_OFF_ENABLE_2);
	assign wr_control = do_write & (addr_reg == `PIF_OFF_CONTROL);

	always_comb begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			BUS_IDLE: begin
				if (take_req) begin
					bus_state_next = BUS_ACCESS;
				end
			end
			BUS_ACCESS: begin
				bus_state_next = BUS_IDLE;
			end
			default: begin
				bus_state_next = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_state_reg <= BUS_IDLE;
		end else begin
			bus_state_reg <= bus_state_next;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_reg <= '0;
			write_reg <= 1'b0;
		end else if (take_req && bus_state_reg == BUS_IDLE) begin
			addr_reg <= haddr[`PIF_ADDR_BITS-1:0];
			write_reg <= hwrite;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Unmapped offsets read zero; hsize is not checked, word access assumed.
	always_comb begin
		read_mux = 32'h0000_0000;
		case (addr_reg)
			`PIF_OFF_FLAGS_1: begin
				read_mux[7:0] = flags_1_reg & `PIF_F1_IMPL_MASK; // [R3]
			end
			`PIF_OFF_FLAGS_2: begin
				read_mux[7:0] = flags_2_reg & `PIF_F2_IMPL_MASK; // [R13]
			end
			`PIF_OFF_ENABLE_1: begin
				read_mux[7:0] = enable_1_reg;
			end
			`PIF_OFF_ENABLE_2: begin
				read_mux[7:0] = enable_2_reg & `PIF_F2_IMPL_MASK;
			end
			`PIF_OFF_CONTROL: begin
				read_mux[1:0] = control_reg;
			end
			`PIF_OFF_PENDING: begin
				read_mux[7:0] = (flags_1_reg & enable_1_reg) | (flags_2_reg & enable_2_reg);
			end
			default: begin
				read_mux = 32'h0000_0000;
			end
		endcase
	end

	// One wait state: data is sampled after any write of the same phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (do_access && !write_reg) begin
			hrdata_reg <= read_mux;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_reg <= 1'b1;
		end else if (take_req && bus_state_reg == BUS_IDLE) begin
			hreadyout_reg <= 1'b0;
		end else begin
			hreadyout_reg <= 1'b1;
		end
	end

	// Always OKAY; unmapped accesses are harmless.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp_reg <= 1'b0;
		end else begin
			hresp_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Request register one
	// ----------------------------------------
	pif_flags_t set_1;
	pif_flags_t level_1;
	pif_flags_t keep_1;

	always_comb begin
		set_1 = 8'h00;
		set_1[`PIF_F1_TIMER1_GATE] = timer1_gate_event; // [R5]
		set_1[`PIF_F1_ADC_DONE] = adc_done_event; // [R6]
		set_1[`PIF_F1_SYNC_SERIAL] = sync_serial_event; // [R9]
		set_1[`PIF_F1_CAPCOMP1] = capcomp_unit1_event; // [R9]
		set_1[`PIF_F1_TIMER2_MATCH] = timer2_match_event; // [R5]
		set_1[`PIF_F1_TIMER1_OVF] = timer1_overflow_event; // [R5]
	end

	always_comb begin
		level_1 = 8'h00;
		level_1[`PIF_F1_SERIAL_RX] = serial_rx_pending; // [R7]
		level_1[`PIF_F1_SERIAL_TX] = serial_tx_pending; // [R8]
	end

	// Software write replaces the stored value, a set then overrides it.
	assign keep_1 = wr_flags_1 ? hwdata[7:0] : flags_1_reg; // [R15]

	// Serial bits follow the peripheral, so no write can touch them.
	assign flags_1_next = (level_1 & `PIF_F1_RO_MASK)
		| ((set_1 | keep_1) & ~`PIF_F1_RO_MASK); // [R1] [R7] [R8] [R15]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_1_reg <= `PIF_RST_FLAGS; // [R4]
		end else begin
			flags_1_reg <= flags_1_next;
		end
	end

	// ----------------------------------------
	// Request register two
	// ----------------------------------------
	pif_flags_t set_2;
	pif_flags_t keep_2;

	always_comb begin
		set_2 = 8'h00;
		set_2[`PIF_F2_OSC_FAIL] = osc_fail_event; // [R10]
		set_2[`PIF_F2_COMPARATOR2] = comparator_two_event; // [R10]
		set_2[`PIF_F2_COMPARATOR1] = comparator_one_event; // [R10]
		set_2[`PIF_F2_EEPROM_DONE] = eeprom_write_done_event; // [R11]
		set_2[`PIF_F2_BUS_COLLISION] = bus_collision_event; // [R11]
		set_2[`PIF_F2_LCD_EVENT] = lcd_event; // [R12]
		set_2[`PIF_F2_CAPCOMP2] = capcomp_unit2_event; // [R12]
	end

	assign keep_2 = wr_flags_2 ? hwdata[7:0] : flags_2_reg; // [R15]

	// Unimplemented bit is masked so it never holds a one.
	assign flags_2_next = (set_2 | keep_2) & `PIF_F2_IMPL_MASK; // [R1] [R13] [R15]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_2_reg <= `PIF_RST_FLAGS; // [R4]
		end else begin
			flags_2_reg <= flags_2_next;
		end
	end

	// ----------------------------------------
	// Enables and control
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_1_reg <= `PIF_RST_ENABLE;
		end else if (wr_enable_1) begin
			enable_1_reg <= hwdata[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_2_reg <= `PIF_RST_ENABLE;
		end else if (wr_enable_2) begin
			enable_2_reg <= hwdata[7:0] & `PIF_F2_IMPL_MASK;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			control_reg <= `PIF_RST_CONTROL;
		end else if (wr_control) begin
			control_reg <= hwdata[1:0];
		end
	end

	// ----------------------------------------
	// Interrupt request
	// ----------------------------------------
	// Built from stored flags and registered, so it lags a new event by two cycles.
	assign irq_next = control_reg[`PIF_CTL_GLOBAL_EN]
		& control_reg[`PIF_CTL_PERIPH_EN]
		& (|((flags_1_reg & enable_1_reg) | (flags_2_reg & enable_2_reg))); // [R14]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign hrdata = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp = hresp_reg;
	assign peripheral_request_flags_1 = flags_1_reg;
	assign peripheral_request_flags_2 = flags_2_reg;
	assign peripheral_irq_request = irq_reg;

endmodule : pif_top

`default_nettype wire

// [testbench/pif_periph_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pif_periph_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [15:0] fire,
	output logic [15:0] ev
);
	// Launched on the clock so events never race the flag registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ev <= 16'h0000;
		end else begin
			ev <= fire & 16'hfffd;
		end
	end
endmodule : pif_periph_model
`default_nettype wire

// [testbench/pif_top_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module pif_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic timer1_gate_event,
	input wire logic serial_rx_pending,
	input wire logic serial_tx_pending,
	input wire logic osc_fail_event,
	input wire logic capcomp_unit2_event,
	input wire logic [7:0] peripheral_request_flags_1,
	input wire logic [7:0] peripheral_request_flags_2,
	input wire logic peripheral_irq_request
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ----
	// Flag, bus wait-state and interrupt checks
	// ----
	a_gate_sets: assert property (timer1_gate_event |=> peripheral_request_flags_1[7])
		else $error("gate flag not set");
	a_osc_sets: assert property (osc_fail_event |=> peripheral_request_flags_2[7])
		else $error("osc flag not set");
	a_cap2_sets: assert property (capcomp_unit2_event |=> peripheral_request_flags_2[0])
		else $error("capture two flag not set");
	a_serial_copy: assert property (1'b1 |=>
		peripheral_request_flags_1[5:4] == $past({serial_rx_pending, serial_tx_pending}))
		else $error("serial flags not copied");
	a_bit1_zero: assert property (peripheral_request_flags_2[1] == 1'b0)
		else $error("unused bit not zero");
	a_one_wait: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
		else $error("wait state wrong");
	a_irq_cause: assert property (peripheral_irq_request |-> $past(|{peripheral_request_flags_1,
		peripheral_request_flags_2})) else $error("request without flag");
	// Only a write of zero may drop the timer-1 gate flag
	a_clear_by_write: assert property ($fell(peripheral_request_flags_1[7]) |->
		$past(hsel && htrans[1] && hwrite, 2) && !$past(hwdata[7])) else $error("flag lost");
	c_irq: cover property ($rose(peripheral_irq_request));
	c_clear: cover property ($fell(peripheral_request_flags_1[7]));
	c_cap2: cover property (capcomp_unit2_event ##1 peripheral_request_flags_2[0]);
endmodule : pif_checker
bind pif_top pif_checker i_pif_checker (.*);
`default_nettype wire

// [testbench/test_peripheral_interrupt_flags.sv]
`timescale 1ns/100ps
`default_nettype none
module test_peripheral_interrupt_flags;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [7:0] f1, f2;
	logic [15:0] fire, ev, exp;
	int n_fail, cmp_count, cyc;
	pif_top i_pif_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .timer1_gate_event(ev[15]), .adc_done_event(ev[14]),
		.serial_rx_pending(ev[13]), .serial_tx_pending(ev[12]), .sync_serial_event(ev[11]),
		.capcomp_unit1_event(ev[10]), .timer2_match_event(ev[9]), .timer1_overflow_event(ev[8]),
		.osc_fail_event(ev[7]), .comparator_two_event(ev[6]), .comparator_one_event(ev[5]),
		.eeprom_write_done_event(ev[4]), .bus_collision_event(ev[3]), .lcd_event(ev[2]),
		.capcomp_unit2_event(ev[0]), .peripheral_request_flags_1(f1), .peripheral_request_flags_2(f2),
		.peripheral_irq_request(irq));
	pif_periph_model i_pif_periph_model (.hclk(hclk), .hresetn(hresetn), .fire(fire), .ev(ev));
	// ----
	// Tasks
	// ----
	task automatic stop_test();
		if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, want, seen);
		end
	endtask : chk
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask : bus
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] want);
		bus(a, 1'b0, 32'h0);
		chk(nm, q, want);
		chk("okay response", {31'h0, hresp}, 32'h0);
	endtask : rd
	task automatic pulse(input logic [15:0] v);
		fire <= v;
		@(posedge hclk);
		fire <= 16'h0;
		repeat (3) @(posedge hclk);
	endtask : pulse
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// Ceiling well above the fewer than two hundred cycles the sequence needs
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			stop_test();
		end
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		fire = 16'h0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("reset flags", {16'h0, f1, f2}, 32'h0);
		rd("flags one", 8'h00, 32'h0);
		rd("flags two", 8'h04, 32'h0);
		exp = 16'h0;
		for (int i = 0; i < 16; i++) begin
			pulse(16'h1 << i);
			exp = exp | ((16'h1 << i) & 16'hcffd);
			chk("event flags", {16'h0, f1, f2}, {16'h0, exp});
		end
		rd("flags one", 8'h00, 32'hcf);
		rd("flags two", 8'h04, 32'hfd);
		bus(8'h00, 1'b1, 32'h0);
		bus(8'h04, 1'b1, 32'h0);
		chk("cleared", {16'h0, f1, f2}, 32'h0);
		bus(8'h00, 1'b1, 32'hff);
		bus(8'h04, 1'b1, 32'hff);
		chk("set by write", {16'h0, f1, f2}, 32'hcffd);
		fire <= 16'h3000;
		bus(8'h00, 1'b1, 32'h0);
		rd("serial levels", 8'h00, 32'h30);
		fire <= 16'h0;
		repeat (3) @(posedge hclk);
		chk("serial idle", {24'h0, f1}, 32'h0);
		bus(8'h04, 1'b1, 32'h0);
		bus(8'h0c, 1'b1, 32'h1);
		bus(8'h10, 1'b1, 32'h2);
		pulse(16'h0001);
		chk("irq blocked", {31'h0, irq}, 32'h0);
		rd("pending", 8'h14, 32'h1);
		bus(8'h10, 1'b1, 32'h3);
		repeat (2) @(posedge hclk);
		chk("irq raised", {31'h0, irq}, 32'h1);
		bus(8'h04, 1'b1, 32'h0);
		repeat (2) @(posedge hclk);
		chk("irq dropped", {31'h0, irq}, 32'h0);
		// Event lands on the very edge that writes zero
		fork
			bus(8'h04, 1'b1, 32'h0);
			begin
				fire <= 16'h0001;
				@(posedge hclk);
				fire <= 16'h0;
			end
		join
		chk("set wins", {24'h0, f2}, 32'h1);
		bus(8'h0c, 1'b1, 32'h2);
		rd("enable two", 8'h0c, 32'h0);
		bus(8'h08, 1'b1, 32'h80);
		rd("enable one", 8'h08, 32'h80);
		rd("control", 8'h10, 32'h3);
		chk("irq masked", {31'h0, irq}, 32'h0);
		rd("unmapped", 8'h20, 32'h0);
		pulse(16'h8000);
		chk("irq from one", {31'h0, irq}, 32'h1);
		rd("pending one", 8'h14, 32'h80);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("second reset", {15'h0, irq, f1, f2}, 32'h0);
		stop_test();
	end
endmodule : test_peripheral_interrupt_flags
`default_nettype wire
